// ==== fes_pkg.sv ====
// Package: constants and carrier types for the flash bus sequencer
`default_nettype none
package fes_pkg;
  // ****************************************************************
  // Timing (100 MHz clock)
  // ****************************************************************
  localparam int CLK_NS = 10;
  localparam int RESET_SETUP_US = 4;
  localparam int RESET_SETUP_CYC =
    (RESET_SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int RESET_HOLD_US = 4;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_DLY_NS = 90;
  localparam int BUSY_DLY_CYC = (BUSY_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int ABORT_US = 20;
  localparam int ABORT_CYC = ABORT_US * 1000 / CLK_NS;
  localparam int PULSE_NS = 40;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_PULSE_NS = 500;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  // ****************************************************************
  // Protect address bits and status toggle data bits
  // ****************************************************************
  localparam int PROT_SEL_BIT = 6;
  localparam int PROT_A1_BIT = 1;
  localparam int PROT_A0_BIT = 0;
  localparam int TOGGLE_BIT = 6;
  localparam int SUSP_TOGGLE_BIT = 2;
  // ****************************************************************
  // Host registers
  // ****************************************************************
  localparam logic [3:0] REG_ADDR = 4'h0;
  localparam logic [3:0] REG_WDATA = 4'h1;
  localparam logic [3:0] REG_CTRL = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h5;
  localparam logic [3:0] REG_IRQ_CLR = 4'h6;
  localparam logic [3:0] REG_IRQ_EN = 4'h7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Control command codes, written to bits 2:0 of REG_CTRL
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_POLL = 3'h3;
  localparam logic [2:0] CMD_RESET = 3'h4;
  localparam int CTRL_UNLOCK_BIT = 3;
  localparam int CTRL_ACCEL_BIT = 4;
  localparam int CTRL_PROT_BIT = 5;
  localparam int CTRL_UNPROT_BIT = 6;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_READY = 1;
  localparam int IRQ_TOGGLE = 2;

  typedef enum logic [7:0] {
    FES_IDLE = 8'h01,
    FES_RD = 8'h02,
    FES_WR = 8'h04,
    FES_GAP = 8'h08,
    FES_UNLK = 8'h10,
    FES_HOLD = 8'h20,
    FES_RST = 8'h40,
    FES_WAIT = 8'h80
  } fes_state_t;

  // Flash pin bundle driven by the sequencer
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic unlock_hv;
    logic accel_hv;
    logic word_byte_select;
  } fes_pins_t;
endpackage : fes_pkg
`default_nettype wire

// ==== fes_host.sv ====
// Module: host sequencer driving an asynchronous NOR flash
//
// Functional notes
// (R1) Program takes 7 us word, 5 us byte
// (R2) Accelerated program completes in about 4 us
// (R3) Sector erase keeps device busy 0.4 s; the model uses 3000 cycles (30 us)
// (R4) Busy asserted within 90 ns of final write
// (R5) Cross-bank read and write need no gap
// (R6) Hold unlock level 4 us before writes
// (R7) Hold unlock level 4 us after ready
// (R8) Suspend toggle bit toggles in suspended sector
// (R9) Toggle output enable between status reads
// (R10) Main toggle bit readable at any address
// (R11) Protect: A6 low, A1 high, A0 low
// (R12) Unprotect: A6 high, A1 high, A0 low
// (R13) Next write immediately after ready returns
// (R14) Reset aborts algorithm within 20 us
// (R15) Ready/busy low during whole algorithm
`timescale 1ns/1ps
`default_nettype none
module fes_host #(
  parameter int AW = 22,
  parameter int DW = 16,
  parameter int ABORT_CYC = fes_pkg::ABORT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  output logic [AW-1:0] flash_addr_o,
  output logic [DW-1:0] flash_dq_o,
  output logic flash_dq_oe_n_o,
  input wire logic [DW-1:0] flash_dq_i,
  output fes_pkg::fes_pins_t flash_pins_o,
  input wire logic ready_busy_n_i
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  fes_pkg::fes_state_t state_r;
  fes_pkg::fes_state_t state_nxt;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic [DW-1:0] rdata_r;
  logic [7:0] ctrl_r;
  logic [2:0] cmd_r;
  logic [31:0] cnt_r;
  logic [fes_pkg::IRQ_W-1:0] irq_stat_r;
  logic [fes_pkg::IRQ_W-1:0] irq_en_r;
  logic ready_d_r;
  logic busy_seen_r;
  logic toggled_r;
  logic unlock_r;
  logic done_ev;
  logic tog_ev;
  logic rdy_ev;
  logic cmd_go;
  logic cnt_zero;

  function automatic logic is_reg(input logic [3:0] a, input logic [3:0] r);
    is_reg = (a == r);
  endfunction : is_reg

  assign cmd_go = ce_i && reg_wr_i && is_reg(reg_addr_i, fes_pkg::REG_CTRL)
                  && state_r == fes_pkg::FES_IDLE;
  assign cnt_zero = (cnt_r == 32'h0000_0000);

  // ****************************************************************
  // Command and address registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      addr_r <= '0;
      wdata_r <= '0;
      ctrl_r <= fes_pkg::CTRL_RESET;
      cmd_r <= 3'h0;
    end else if (ce_i && reg_wr_i) begin
      if (is_reg(reg_addr_i, fes_pkg::REG_ADDR)) begin
        addr_r <= reg_wdata_i[AW-1:0];
      end else if (is_reg(reg_addr_i, fes_pkg::REG_WDATA)) begin
        wdata_r <= reg_wdata_i[DW-1:0];
      end else if (is_reg(reg_addr_i, fes_pkg::REG_CTRL)) begin
        ctrl_r <= reg_wdata_i[7:0];
        if (state_r == fes_pkg::FES_IDLE) begin
          cmd_r <= reg_wdata_i[2:0];
        end
      end
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fes_pkg::FES_IDLE: begin
        if (cmd_go) begin
          if (reg_wdata_i[fes_pkg::CTRL_UNLOCK_BIT] && !unlock_r)
            state_nxt = fes_pkg::FES_UNLK;
          else if (reg_wdata_i[2:0] == fes_pkg::CMD_WRITE)
            state_nxt = fes_pkg::FES_WR;
          else if (reg_wdata_i[2:0] == fes_pkg::CMD_RESET)
            state_nxt = fes_pkg::FES_RST;
          else if (reg_wdata_i[2:0] == fes_pkg::CMD_READ ||
                   reg_wdata_i[2:0] == fes_pkg::CMD_POLL)
            state_nxt = fes_pkg::FES_RD;
          else if (!reg_wdata_i[fes_pkg::CTRL_UNLOCK_BIT] && unlock_r)
            state_nxt = fes_pkg::FES_HOLD;
        end
      end
      fes_pkg::FES_UNLK: begin
        // Unlock level must settle before any protected write
        if (cnt_zero) state_nxt = fes_pkg::FES_IDLE; // see (R6)
      end
      fes_pkg::FES_RD: if (cnt_zero) state_nxt = fes_pkg::FES_GAP;
      fes_pkg::FES_WR: if (cnt_zero) state_nxt = fes_pkg::FES_WAIT;
      fes_pkg::FES_WAIT: begin
        // Busy shows within 90 ns, then stays low until done
        if (cnt_zero && (busy_seen_r || ready_busy_n_i))
          state_nxt = ready_busy_n_i ? fes_pkg::FES_IDLE
                                     : fes_pkg::FES_WAIT; // see (R4) (R15)
      end
      fes_pkg::FES_GAP: begin
        // Output enable high between reads so toggle bits advance
        if (cnt_zero) state_nxt = fes_pkg::FES_IDLE; // see (R9)
      end
      fes_pkg::FES_RST: begin
        // Device returns to read mode within the abort window
        if (cnt_zero) state_nxt = fes_pkg::FES_IDLE; // see (R14)
      end
      fes_pkg::FES_HOLD: begin
        // Unlock level kept after ready returns high
        if (cnt_zero && ready_busy_n_i)
          state_nxt = fes_pkg::FES_IDLE; // see (R7)
      end
      default: state_nxt = fes_pkg::FES_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= fes_pkg::FES_IDLE;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Cycle counter, reloaded on each state entry
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_r <= 32'h0000_0000;
    end else if (ce_i) begin
      if (state_nxt != state_r) begin
        case (state_nxt)
          fes_pkg::FES_UNLK: cnt_r <= 32'(fes_pkg::RESET_SETUP_CYC);
          fes_pkg::FES_HOLD: cnt_r <= 32'(fes_pkg::RESET_HOLD_CYC);
          fes_pkg::FES_WAIT: cnt_r <= 32'(fes_pkg::BUSY_DLY_CYC);
          fes_pkg::FES_RST: cnt_r <= 32'(ABORT_CYC);
          fes_pkg::FES_IDLE: cnt_r <= 32'h0000_0000;
          default: cnt_r <= 32'(fes_pkg::PULSE_CYC);
        endcase
      end else if (state_r == fes_pkg::FES_HOLD && !ready_busy_n_i) begin
        cnt_r <= 32'(fes_pkg::RESET_HOLD_CYC);
      end else if (!cnt_zero) begin
        cnt_r <= cnt_r - 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // Unlock level, busy tracking and read capture
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      unlock_r <= 1'b0;
    end else if (ce_i) begin
      if (state_r == fes_pkg::FES_IDLE && state_nxt == fes_pkg::FES_UNLK)
        unlock_r <= 1'b1;
      else if (state_r == fes_pkg::FES_HOLD && state_nxt == fes_pkg::FES_IDLE)
        unlock_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      busy_seen_r <= 1'b0;
      ready_d_r <= 1'b1;
    end else if (ce_i) begin
      ready_d_r <= ready_busy_n_i;
      if (state_r != fes_pkg::FES_WAIT) busy_seen_r <= 1'b0;
      else if (!ready_busy_n_i) busy_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_r <= '0;
      toggled_r <= 1'b0;
    end else if (ce_i && state_r == fes_pkg::FES_RD && cnt_zero) begin
      // Main toggle bit valid at any address; suspend bit per sector
      rdata_r <= flash_dq_i; // see (R10) (R8)
      toggled_r <= (flash_dq_i[fes_pkg::TOGGLE_BIT] !=
                    rdata_r[fes_pkg::TOGGLE_BIT]);
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign done_ev = ce_i && state_r == fes_pkg::FES_WAIT &&
                   state_nxt == fes_pkg::FES_IDLE;
  assign rdy_ev = ce_i && ready_busy_n_i && !ready_d_r;
  assign tog_ev = ce_i && state_r == fes_pkg::FES_RD && cnt_zero &&
                  cmd_r == fes_pkg::CMD_POLL &&
                  flash_dq_i[fes_pkg::TOGGLE_BIT] !=
                  rdata_r[fes_pkg::TOGGLE_BIT];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
    end else begin
      // Set wins over a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~((ce_i && reg_wr_i &&
                     is_reg(reg_addr_i, fes_pkg::REG_IRQ_CLR)) ?
                     reg_wdata_i[fes_pkg::IRQ_W-1:0] : '0))
                    | {tog_ev, rdy_ev, done_ev};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_en_r <= '0;
    end else if (ce_i && reg_wr_i &&
                 is_reg(reg_addr_i, fes_pkg::REG_IRQ_EN)) begin
      irq_en_r <= reg_wdata_i[fes_pkg::IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat_r & irq_en_r);

  // ****************************************************************
  // Register read port, data one cycle after the strobe
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      reg_rdata_o <= 32'h0000_0000;
      if (reg_rd_i) begin
        if (is_reg(reg_addr_i, fes_pkg::REG_ADDR))
          reg_rdata_o <= 32'(addr_r);
        else if (is_reg(reg_addr_i, fes_pkg::REG_WDATA))
          reg_rdata_o <= 32'(wdata_r);
        else if (is_reg(reg_addr_i, fes_pkg::REG_CTRL))
          reg_rdata_o <= 32'(ctrl_r);
        else if (is_reg(reg_addr_i, fes_pkg::REG_STATUS))
          reg_rdata_o <= {22'h0, state_r, toggled_r, ready_busy_n_i};
        else if (is_reg(reg_addr_i, fes_pkg::REG_RDATA))
          reg_rdata_o <= 32'(rdata_r);
        else if (is_reg(reg_addr_i, fes_pkg::REG_IRQ_STAT))
          reg_rdata_o <= 32'(irq_stat_r);
        else if (is_reg(reg_addr_i, fes_pkg::REG_IRQ_EN))
          reg_rdata_o <= 32'(irq_en_r);
      end
    end
  end

  // ****************************************************************
  // Flash pins
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      flash_addr_o <= '0;
      flash_dq_o <= '0;
    end else if (ce_i) begin
      flash_addr_o <= addr_r;
      // Protect select bits forced for the protect sequences
      if (ctrl_r[fes_pkg::CTRL_PROT_BIT]) begin
        flash_addr_o[fes_pkg::PROT_SEL_BIT] <= 1'b0; // see (R11)
        flash_addr_o[fes_pkg::PROT_A1_BIT] <= 1'b1; // see (R11)
        flash_addr_o[fes_pkg::PROT_A0_BIT] <= 1'b0; // see (R11)
      end else if (ctrl_r[fes_pkg::CTRL_UNPROT_BIT]) begin
        flash_addr_o[fes_pkg::PROT_SEL_BIT] <= 1'b1; // see (R12)
        flash_addr_o[fes_pkg::PROT_A1_BIT] <= 1'b1; // see (R12)
        flash_addr_o[fes_pkg::PROT_A0_BIT] <= 1'b0; // see (R12)
      end
      flash_dq_o <= wdata_r;
    end
  end

  // Write from IDLE straight after ready needs no recovery gap
  always_comb begin
    flash_pins_o.ce_n = !(state_r == fes_pkg::FES_RD ||
                          state_r == fes_pkg::FES_WR); // see (R13) (R5)
    flash_pins_o.oe_n = !(state_r == fes_pkg::FES_RD);
    flash_pins_o.we_n = !(state_r == fes_pkg::FES_WR);
    flash_pins_o.reset_n = !(state_r == fes_pkg::FES_RST);
    flash_pins_o.unlock_hv = unlock_r;
    flash_pins_o.accel_hv = ctrl_r[fes_pkg::CTRL_ACCEL_BIT]; // see (R2)
    flash_pins_o.word_byte_select = ctrl_r[7]; // see (R1)
    flash_dq_oe_n_o = !(state_r == fes_pkg::FES_WR);
  end
endmodule : fes_host
`default_nettype wire

// ==== fes_host_chk.sv ====
// Checker: flash pin protocol of the host sequencer
`timescale 1ns/1ps
`default_nettype none
module fes_host_chk #(
  parameter int AW = 22,
  parameter int DW = 16,
  parameter int ABORT_CYC = 2000
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic flash_dq_oe_n_o,
  input wire fes_pkg::fes_pins_t flash_pins_o,
  input wire logic ready_busy_n_i
);
  // ****
  // Counters saturate so long idle spells never wrap
  // ****
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  fes_pkg::fes_pins_t p;
  logic [15:0] unl_cnt, rdy_cnt, rst_cnt;
  assign p = flash_pins_o;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !p.unlock_hv) unl_cnt <= 16'h0;
    else if (unl_cnt != 16'hFFFF) unl_cnt <= unl_cnt + 16'h1;
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !ready_busy_n_i) rdy_cnt <= 16'h0;
    else if (rdy_cnt != 16'hFFFF) rdy_cnt <= rdy_cnt + 16'h1;
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || p.reset_n) rst_cnt <= 16'h0;
    else if (rst_cnt != 16'hFFFF) rst_cnt <= rst_cnt + 16'h1;
  end
  // ****
  // Pin protocol
  // ****
  AST_UNLOCK_SETUP: assert property (
    $fell(p.we_n) && p.unlock_hv |-> unl_cnt >= fes_pkg::RESET_SETUP_CYC)
    else $error("write under unlock level too early");
  AST_UNLOCK_HOLD: assert property (
    $fell(p.unlock_hv) |-> rdy_cnt >= fes_pkg::RESET_HOLD_CYC)
    else $error("unlock level dropped too soon after ready");
  AST_RST_WIDTH: assert property (
    $rose(p.reset_n) |-> rst_cnt >= ABORT_CYC)
    else $error("device reset pulse too short");
  AST_WE_PULSE: assert property (
    $fell(p.we_n) |-> (!p.we_n) [*5] ##1 p.we_n)
    else $error("write strobe width wrong");
  AST_WR_DRIVE: assert property (
    !p.we_n |-> !flash_dq_oe_n_o && !p.ce_n && p.oe_n)
    else $error("write strobe without data drive");
  AST_RD_FLOAT: assert property (
    !p.oe_n |-> flash_dq_oe_n_o && p.we_n && !p.ce_n)
    else $error("read strobe while driving data");
  AST_RD_LEN: assert property (
    $fell(p.oe_n) |-> (!p.oe_n) [*5] ##1 p.oe_n [*5])
    else $error("read strobe or gap width wrong");
  AST_RDATA_QUIET: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
endmodule : fes_host_chk
bind fes_host fes_host_chk #(.AW(AW), .DW(DW), .ABORT_CYC(ABORT_CYC)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .flash_dq_oe_n_o(flash_dq_oe_n_o),
  .flash_pins_o(flash_pins_o), .ready_busy_n_i(ready_busy_n_i));
`default_nettype wire

// ==== fes_flash_model.sv ====
// Model: asynchronous flash device as seen from its pins
`timescale 1ns/1ps
`default_nettype none
module fes_flash_model #(
  parameter int WORD_CYC = 700,
  parameter int BYTE_CYC = 500,
  parameter int ACC_CYC = 400,
  parameter int ERASE_CYC = 3000,
  parameter int BUSY_CYC = 3,
  parameter int ABORT_DLY = 40,
  parameter logic [5:0] SUSP_SECT = 6'h05
) (
  input wire logic clk_i,
  input wire logic [21:0] addr_i,
  input wire fes_pkg::fes_pins_t pins_i,
  input wire logic erase_i,
  input wire logic susp_i,
  output logic [15:0] dq_o,
  output logic ready_busy_n_o
);
  // ****
  // Embedded algorithm timer; erase is shortened to keep runs brief
  // ****
  int cnt = 0;
  int dur = 0;
  int n;
  logic we_q = 1'b1;
  logic rd_q = 1'b0;
  logic t6 = 1'b0;
  logic t2 = 1'b0;
  logic [15:0] last = 16'h0;
  logic [15:0] val;
  logic rd, insec;
  assign rd = !pins_i.ce_n && !pins_i.oe_n;
  assign insec = susp_i && addr_i[21:16] == SUSP_SECT;
  always @(posedge clk_i) begin
    we_q <= pins_i.we_n;
    n = erase_i ? ERASE_CYC : pins_i.accel_hv ? ACC_CYC :
        pins_i.word_byte_select ? WORD_CYC : BYTE_CYC;
    if (!we_q && pins_i.we_n) begin
      dur <= n;
      cnt <= n;
    end else if (!pins_i.reset_n && cnt > ABORT_DLY) begin
      cnt <= ABORT_DLY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign ready_busy_n_o = cnt == 0 || dur - cnt < BUSY_CYC;
  // ****
  // Read path; a released bus shows the inverse of the last value
  // ****
  always @(posedge clk_i) begin
    rd_q <= rd;
    if (rd) last <= dq_o;
    if (rd && !rd_q && cnt > 0) t6 <= !t6;
    if (rd && !rd_q && insec) t2 <= !t2;
  end
  always_comb begin
    val = ~addr_i[15:0];
    if (cnt > 0 || insec) begin
      val = 16'h0;
      val[fes_pkg::TOGGLE_BIT] = t6;
      val[fes_pkg::SUSP_TOGGLE_BIT] = t2;
    end
  end
  assign dq_o = rd ? val : ~last;
endmodule : fes_flash_model
`default_nettype wire

// ==== fes_host_bench.sv ====
// Testbench: register-level tests of the flash host sequencer
`timescale 1ns/1ps
`default_nettype none
module fes_host_bench;
  localparam logic [31:0] MODE [3] = '{32'h82, 32'h02, 32'h92};
  localparam logic [31:0] IDLE_ST = {22'h0, fes_pkg::FES_IDLE, 2'h1};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic erase = 1'b0;
  logic susp = 1'b0;
  logic [3:0] ra = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdo, d, e;
  logic irq, doe, rb;
  logic [21:0] fa, wa;
  logic [15:0] fdq, mdq, bus, wdq;
  fes_pkg::fes_pins_t pins;
  int fail_count = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  assign bus = doe ? mdq : fdq;
  fes_host #(.ABORT_CYC(60)) u_dut (
    .sys_clk_i(clk), .rst_i(rst), .ce_i(ce), .reg_addr_i(ra),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdo),
    .irq_o(irq), .flash_addr_o(fa), .flash_dq_o(fdq),
    .flash_dq_oe_n_o(doe), .flash_dq_i(bus), .flash_pins_o(pins),
    .ready_busy_n_i(rb));
  fes_flash_model u_dev (
    .clk_i(clk), .addr_i(fa), .pins_i(pins), .erase_i(erase),
    .susp_i(susp), .dq_o(mdq), .ready_busy_n_o(rb));
  always @(posedge clk) if (!pins.we_n) begin
    wa <= fa;
    wdq <= fdq;
  end
  // ****
  // Bus tasks
  // ****
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] x);
    @(posedge clk);
    ra <= a;
    wd <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] x);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    x = rdo;
  endtask : rd_reg
  task automatic cmp(input string n, input logic [31:0] x,
                     input logic [31:0] y);
    cmp_count++;
    if (y !== x) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, x, y);
    end
  endtask : cmp
  // Bounded poll: a hung sequencer ends the run here
  task automatic ctrl(input logic [31:0] c);
    logic [31:0] s;
    int i;
    wr_reg(fes_pkg::REG_CTRL, c);
    for (i = 0; i < 3000; i++) begin
      rd_reg(fes_pkg::REG_STATUS, s);
      if (s[9:2] === fes_pkg::FES_IDLE) break;
    end
    if (i == 3000) begin
      cmp("idle", 32'h1, 32'h0);
      final_report;
    end
  endtask : ctrl
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // ****
  // Tests
  // ****
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_reg(fes_pkg::REG_STATUS, d);
    cmp("status", IDLE_ST, d);
    rd_reg(fes_pkg::REG_IRQ_EN, d);
    cmp("irq_en", 32'h0, d);
    rd_reg(4'hF, d);
    cmp("unmapped", 32'h0, d);
    // Clock enable low must drop a register write
    ce <= 1'b0;
    wr_reg(fes_pkg::REG_IRQ_EN, 32'h7);
    ce <= 1'b1;
    rd_reg(fes_pkg::REG_IRQ_EN, d);
    cmp("ce_freeze", 32'h0, d);
    $display("test reset done");
    wr_reg(fes_pkg::REG_IRQ_EN, 32'h7);
    for (int m = 0; m < 3; m++) begin
      e = 32'h3F1230 + m;
      wr_reg(fes_pkg::REG_ADDR, e);
      wr_reg(fes_pkg::REG_WDATA, 32'h5A00 + m);
      ctrl(MODE[m]);
      cmp("ready", 32'h1, 32'(rb));
      cmp("wr_addr", e, 32'(wa));
      cmp("wr_data", 32'h5A00 + m, 32'(wdq));
      cmp("irq_o", 32'h1, 32'(irq));
      wr_reg(fes_pkg::REG_IRQ_CLR, 32'h7);
      cmp("irq_clr", 32'h0, 32'(irq));
      wr_reg(fes_pkg::REG_ADDR, e ^ 32'h200000);
      ctrl(32'(fes_pkg::CMD_READ));
      rd_reg(fes_pkg::REG_RDATA, d);
      cmp("rdata", {16'h0, ~e[15:0]}, d);
    end
    $display("test program done");
    wr_reg(fes_pkg::REG_IRQ_EN, 32'h0);
    erase <= 1'b1;
    ctrl(MODE[0]);
    erase <= 1'b0;
    cmp("erase_ready", 32'h1, 32'(rb));
    cmp("irq_mask", 32'h0, 32'(irq));
    rd_reg(fes_pkg::REG_IRQ_STAT, d);
    cmp("irq_pend", 32'h3, d & 32'h3);
    susp <= 1'b1;
    wr_reg(fes_pkg::REG_ADDR, 32'h050000);
    ctrl(32'(fes_pkg::CMD_POLL));
    rd_reg(fes_pkg::REG_RDATA, d);
    ctrl(32'(fes_pkg::CMD_POLL));
    rd_reg(fes_pkg::REG_RDATA, e);
    cmp("susp_toggle", d ^ 32'h4, e);
    wr_reg(fes_pkg::REG_IRQ_CLR, 32'h7);
    wr_reg(fes_pkg::REG_ADDR, 32'h010000);
    ctrl(32'(fes_pkg::CMD_POLL));
    rd_reg(fes_pkg::REG_RDATA, d);
    cmp("no_toggle", 32'hFFFF, d);
    rd_reg(fes_pkg::REG_IRQ_STAT, d);
    cmp("irq_tog", 32'h4, d & 32'h4);
    $display("test erase done");
    ctrl(32'h8);
    cmp("unlock_on", 32'h1, 32'(pins.unlock_hv));
    wr_reg(fes_pkg::REG_ADDR, 32'h41);
    ctrl(32'h2A);
    cmp("prot_addr", 32'h2, 32'(wa) & 32'h43);
    wr_reg(fes_pkg::REG_ADDR, 32'h0);
    ctrl(32'h4A);
    cmp("unprot_addr", 32'h42, 32'(wa) & 32'h43);
    ctrl(32'h0);
    cmp("unlock_off", 32'h0, 32'(pins.unlock_hv));
    $display("test unlock done");
    ctrl(32'(fes_pkg::CMD_RESET));
    rd_reg(fes_pkg::REG_STATUS, d);
    cmp("status_rst", IDLE_ST | 32'h2, d);
    cmp("reset_pin", 32'h1, 32'(pins.reset_n));
    $display("test reset pulse done");
    final_report;
  end
endmodule : fes_host_bench
`default_nettype wire
